// [hw/ivpm_map.svh]
`ifndef IVPM_MAP_SVH
`define IVPM_MAP_SVH
// APB register byte offsets
`define IVPM_OFS_CTRL 12'h000
`define IVPM_OFS_ELEV 12'h004
`define IVPM_OFS_STAT 12'h008
`define IVPM_OFS_MASK 12'h00c
`define IVPM_OFS_VEC 12'h010
// Control register fields
`define IVPM_CTRL_IMASK 0
`define IVPM_CTRL_UNDERFLOW 1
`define IVPM_CTRL_ACCAEDGE 2
`define IVPM_CTRL_SPI 3
`define IVPM_CTRL_ACCBOVF 4
`define IVPM_CTRL_LOCK 5
`define IVPM_CTRL_LIMP 6
`define IVPM_CTRL_CLKMON 7
`define IVPM_CTRL_FCLKMON 8
`define IVPM_CTRL_CH0 12
`define IVPM_CTRL_CH1 16
// Reset values
`define IVPM_CTRL_RST 32'h0000_0001
`define IVPM_ELEV_RST 8'hf2
// Vector addresses
`define IVPM_VEC_CLKFAIL 16'hfffc
`define IVPM_VEC_EXTIRQ 16'hfff2
`define IVPM_VEC_ACCAEDGE 16'hffda
`define IVPM_VEC_SPI 16'hffd8
`define IVPM_VEC_CH0 16'hffd6
`define IVPM_VEC_CH1 16'hffd4
`define IVPM_VEC_UNDERFLOW 16'hffcc
`define IVPM_VEC_ACCBOVF 16'hffca
`define IVPM_VEC_CLKGEN 16'hffc2
`define IVPM_VEC_NONE 16'h0000
// Highest code that may be elevated
`define IVPM_ELEV_MAX 8'hf2
`endif

// [hw/ivpm_pkg.sv]
package ivpm_pkg;
    // Maskable source indices, in default priority order (highest first)
    typedef enum logic [2:0] {
        SRC_EXTIRQ, SRC_ACCAEDGE, SRC_SPI, SRC_CH0, SRC_CH1, SRC_UNDERFLOW, SRC_ACCBOVF, SRC_CLKGEN
    } ivpm_src_t;
    // Serial channel request and enable group
    typedef struct packed {
        logic idleLine;
        logic rxFull;
        logic txComplete;
        logic txEmpty;
    } ivpm_ser_t;
    // APB slave request carrier
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } ivpm_apb_req_t;
    // Main state
    typedef struct packed {
        logic [31:0] ctrl;
        logic [7:0] elev;
        logic [8:0] stat;
        logic [8:0] mask;
        logic [15:0] vec;
        logic vecValid;
        logic [31:0] prdata;
        logic pslverr;
        logic ack; // Answer registered, pready up for one cycle
    } ivpm_state_t;
endpackage : ivpm_pkg

// [hw/ivpm_sync.sv]
`timescale 1ns/1ns
`default_nettype none
// Three-stage synchroniser; output moves once stages two and three agree
module ivpm_sync
    import ivpm_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clkEn,
    // Data
    input wire logic pinIn,
    output logic pinOut
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic out;
    } ivpm_sync_t;
    ivpm_sync_t state_q;
    ivpm_sync_t state_d;
    ////////////////////////////////////////////////////////////////
    // Next state; stage one feeds only stage two
    always_comb begin
        state_d = state_q;
        if (clkEn) begin
            state_d.s1 = pinIn;
            state_d.s2 = state_q.s1;
            state_d.s3 = state_q.s2;
            // Filter glitch of one sample
            if (state_q.s2 == state_q.s3) begin
                state_d.out = state_q.s3;
            end
        end
    end
    // Registers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end
    assign pinOut = state_q.out;
endmodule : ivpm_sync
`default_nettype wire

// [hw/ivpm_prio.sv]
`timescale 1ns/1ns
`default_nettype none
`include "ivpm_map.svh"
// Picks the vector: elevated source first, then descending address
module ivpm_prio
    import ivpm_pkg::*;
(
    // Requests, already gated by enables and global mask
    input wire logic [7:0] req,
    input wire logic [7:0] elevCode,
    // Chosen vector
    output logic [15:0] vec,
    output logic valid
);
    // Vector table indexed by source
    function automatic logic [15:0] vecOf(input int i);
        case (i)
            0: vecOf = `IVPM_VEC_EXTIRQ;
            1: vecOf = `IVPM_VEC_ACCAEDGE;
            2: vecOf = `IVPM_VEC_SPI;
            3: vecOf = `IVPM_VEC_CH0;
            4: vecOf = `IVPM_VEC_CH1;
            5: vecOf = `IVPM_VEC_UNDERFLOW;
            6: vecOf = `IVPM_VEC_ACCBOVF;
            7: vecOf = `IVPM_VEC_CLKGEN;
            default: vecOf = `IVPM_VEC_NONE;
        endcase
    endfunction : vecOf
    ////////////////////////////////////////////////////////////////
    // Selection
    always_comb begin
        logic [7:0] elevHit;
        logic known;
        logic [15:0] cand;
        elevHit = '0;
        known = 1'b0;
        cand = `IVPM_VEC_NONE;
        vec = `IVPM_VEC_NONE;
        valid = 1'b0;
        for (int i = 0; i < 8; i++) begin
            // A function result cannot be part-selected directly
            cand = vecOf(i);
            if (cand[7:0] == elevCode) begin
                elevHit[i] = 1'b1;
                known = 1'b1;
            end
        end
        // Unknown or over-range code falls back to the external pin
        if (!known || elevCode > `IVPM_ELEV_MAX) begin
            elevHit = 8'h01;
        end
        // Default order, lowest index is highest address
        for (int i = 7; i >= 0; i--) begin
            if (req[i]) begin
                vec = vecOf(i);
                valid = 1'b1;
            end
        end
        // Elevated source overrides
        if (|(req & elevHit)) begin
            for (int i = 0; i < 8; i++) begin
                if (req[i] && elevHit[i]) begin
                    vec = vecOf(i);
                end
            end
        end
    end
endmodule : ivpm_prio
`default_nettype wire

// [hw/ivpm_top.sv]
// Overview of operation
// - Clock failure vectors FFFC, monitor enables only
// - Underflow vectors FFCC, gated, elevate with CC
// - Accumulator A edge vectors FFDA, elevate DA
// - SPI complete vectors FFD8, elevate D8
// - Accumulator B overflow vectors FFCA, elevate CA
// - Lock or limp-home vectors FFC2, elevate C2
// - Serial channels FFD6 and FFD4, ORed sources
// - Maskables seen only while I clear
// - Elevation write accepted only while I set
// - Bad elevation code makes pin highest
`timescale 1ns/1ns
`default_nettype none
`include "ivpm_map.svh"
module ivpm_top
    import ivpm_pkg::*;
(
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clkEn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Peripheral requests, same clock
    input wire logic clockFailReq,
    input wire logic underflowReq,
    input wire logic accAEdgeReq,
    input wire logic spiDoneReq,
    input wire logic accBOverflowReq,
    input wire logic lockReq,
    input wire logic limpHomeReq,
    input wire ivpm_ser_t ch0Req,
    input wire ivpm_ser_t ch1Req,
    // External maskable pin, asynchronous, active low
    input wire logic extIrq_b,
    // Core side
    output logic [15:0] vectorAddr,
    output logic vectorValid,
    output logic irq
);
    ivpm_state_t state_q; // All state
    ivpm_state_t state_d; // Next state
    ivpm_apb_req_t apb; // Bundled bus request
    logic extIrqSync; // Synchronised pin request, active high
    logic [7:0] gatedReq; // Maskable requests after gating
    logic [7:0] rawReq; // Maskable requests after local enable
    logic clkFailEn; // Clock monitor armed
    logic clkFail; // Clock fail reset request
    logic [15:0] selVec; // Arbiter choice
    logic selValid; // Arbiter found a request
    logic iMask; // Global I bit
    logic [3:0] ch0En; // Channel 0 enables
    logic [3:0] ch1En; // Channel 1 enables
    logic [8:0] events; // Sticky event sources
    logic accessDone; // Access phase completes
    assign apb = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
    ////////////////////////////////////////////////////////////////
    // Pin synchroniser; fed inverted so its reset value is the idle level
    ivpm_sync uSync (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .clkEn(clkEn),
        .pinIn(~extIrq_b),
        .pinOut(extIrqSync)
    );
    ////////////////////////////////////////////////////////////////
    // Request gating
    assign iMask = state_q.ctrl[`IVPM_CTRL_IMASK];
    assign ch0En = state_q.ctrl[`IVPM_CTRL_CH0 +: 4];
    assign ch1En = state_q.ctrl[`IVPM_CTRL_CH1 +: 4];
    // Clock fail ignores I, armed by either monitor bit
    assign clkFailEn = state_q.ctrl[`IVPM_CTRL_CLKMON] | state_q.ctrl[`IVPM_CTRL_FCLKMON];
    assign clkFail = clockFailReq & clkFailEn;
    always_comb begin
        rawReq = '0;
        rawReq[SRC_EXTIRQ] = extIrqSync;
        rawReq[SRC_ACCAEDGE] = accAEdgeReq & state_q.ctrl[`IVPM_CTRL_ACCAEDGE];
        rawReq[SRC_SPI] = spiDoneReq & state_q.ctrl[`IVPM_CTRL_SPI];
        rawReq[SRC_CH0] = |(ch0Req & ch0En);
        rawReq[SRC_CH1] = |(ch1Req & ch1En);
        rawReq[SRC_UNDERFLOW] = underflowReq & state_q.ctrl[`IVPM_CTRL_UNDERFLOW];
        rawReq[SRC_ACCBOVF] = accBOverflowReq & state_q.ctrl[`IVPM_CTRL_ACCBOVF];
        // Either lock or limp-home enable arms it
        rawReq[SRC_CLKGEN] = (lockReq & state_q.ctrl[`IVPM_CTRL_LOCK])
                           | (limpHomeReq & state_q.ctrl[`IVPM_CTRL_LIMP]);
    end
    // Global mask blocks all maskables
    assign gatedReq = iMask ? 8'h00 : rawReq;
    assign events = {clkFail, gatedReq};
    ////////////////////////////////////////////////////////////////
    // Arbiter
    ivpm_prio uPrio (
        .req(gatedReq),
        .elevCode(state_q.elev),
        .vec(selVec),
        .valid(selValid)
    );
    ////////////////////////////////////////////////////////////////
    // Next state, including APB access
    // Work is done in the first access cycle only; the next one answers
    assign accessDone = apb.psel & apb.penable & ~state_q.ack;
    always_comb begin
        state_d = state_q;
        if (clkEn) begin
            // Clock fail wins over any maskable choice
            if (clkFail) begin
                state_d.vec = `IVPM_VEC_CLKFAIL;
                state_d.vecValid = 1'b1;
            end else begin
                state_d.vec = selVec;
                state_d.vecValid = selValid;
            end
            state_d.pslverr = 1'b0;
            // One wait state, so read data stand when pready is sampled
            state_d.ack = accessDone;
            // Sticky status; set wins over the read clear
            if (accessDone && !apb.pwrite && apb.paddr == `IVPM_OFS_STAT) begin
                state_d.stat = events;
            end else begin
                state_d.stat = state_q.stat | events;
            end
            if (accessDone) begin
                state_d.prdata = '0;
                if (apb.pwrite) begin
                    case (apb.paddr)
                        `IVPM_OFS_CTRL: state_d.ctrl = apb.pwdata;
                        `IVPM_OFS_ELEV: begin
                            // Dropped silently while I clear
                            if (iMask) begin
                                state_d.elev = apb.pwdata[7:0];
                            end
                        end
                        `IVPM_OFS_MASK: state_d.mask = apb.pwdata[8:0];
                        `IVPM_OFS_STAT: ;
                        `IVPM_OFS_VEC: ;
                        default: state_d.pslverr = 1'b1;
                    endcase
                end else begin
                    case (apb.paddr)
                        `IVPM_OFS_CTRL: state_d.prdata = state_q.ctrl;
                        `IVPM_OFS_ELEV: state_d.prdata = {24'h000000, state_q.elev};
                        `IVPM_OFS_STAT: state_d.prdata = {23'h000000, state_q.stat};
                        `IVPM_OFS_MASK: state_d.prdata = {23'h000000, state_q.mask};
                        `IVPM_OFS_VEC: state_d.prdata = {15'h0000, state_q.vecValid, state_q.vec};
                        default: state_d.pslverr = 1'b1;
                    endcase
                end
            end
        end
    end
    ////////////////////////////////////////////////////////////////
    // Registers; I bit set out of reset
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= '{ctrl: `IVPM_CTRL_RST, elev: `IVPM_ELEV_RST, stat: 9'h000, mask: 9'h000,
                         vec: `IVPM_VEC_NONE, vecValid: 1'b0, prdata: 32'h00000000, pslverr: 1'b0,
                         ack: 1'b0};
        end else begin
            state_q <= state_d;
        end
    end
    ////////////////////////////////////////////////////////////////
    // Outputs; data come from flip-flops, one wait state on every access
    assign prdata = state_q.prdata;
    assign pslverr = state_q.pslverr;
    assign pready = state_q.ack;
    assign vectorAddr = state_q.vec;
    assign vectorValid = state_q.vecValid;
    assign irq = |(state_q.stat & state_q.mask);
endmodule : ivpm_top
`default_nettype wire

// [testbench/ivpm_checker_assertions.sv]
`timescale 1ns/1ns
`default_nettype none
module ivpm_checker
    import ivpm_pkg::*;
(
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clkEn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    // Requests
    input wire logic clockFailReq,
    input wire logic underflowReq,
    input wire logic accAEdgeReq,
    input wire logic spiDoneReq,
    input wire logic accBOverflowReq,
    input wire logic lockReq,
    input wire logic limpHomeReq,
    input wire ivpm_ser_t ch0Req,
    // Core side
    input wire logic [15:0] vectorAddr,
    input wire logic vectorValid
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////
    logic [31:0] ctrlQ; // Shadow of control word
    logic [7:0] elevQ; // Shadow of elevation code
    wire logic wr = psel && penable && pwrite && clkEn;
    // Clock fail outranks mask, so it spoils maskable checks
    wire logic live = clkEn && !ctrlQ[0] && !clockFailReq;
    // Shadows follow bus writes; elevation only while masked
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrlQ <= 32'h0000_0001;
            elevQ <= 8'hf2;
        end else begin
            if (wr && paddr == 12'h000) ctrlQ <= pwdata;
            if (wr && paddr == 12'h004 && ctrlQ[0]) elevQ <= pwdata[7:0];
        end
    end
    ////////////////////////////////////////////////////////////
    clk_fail_a: assert property (clkEn && clockFailReq && (ctrlQ[7] || ctrlQ[8])
        |=> vectorValid && vectorAddr == 16'hfffc) else $error("clock fail vector wrong");
    underflow_vec_a: assert property (live && underflowReq && ctrlQ[1] && elevQ == 8'hcc
        |=> vectorAddr == 16'hffcc) else $error("underflow vector wrong");
    acc_edge_a: assert property (live && accAEdgeReq && ctrlQ[2] && elevQ == 8'hda
        |=> vectorAddr == 16'hffda) else $error("edge vector wrong");
    spi_vec_a: assert property (live && spiDoneReq && ctrlQ[3] && elevQ == 8'hd8
        |=> vectorAddr == 16'hffd8) else $error("spi vector wrong");
    acc_ovf_a: assert property (live && accBOverflowReq && ctrlQ[4] && elevQ == 8'hca
        |=> vectorAddr == 16'hffca) else $error("overflow vector wrong");
    clk_gen_a: assert property (live && (lockReq && ctrlQ[5] || limpHomeReq && ctrlQ[6])
        && elevQ == 8'hc2 |=> vectorAddr == 16'hffc2) else $error("clock gen vector wrong");
    serial_vec_a: assert property (live && |(ch0Req & ctrlQ[15:12]) && elevQ == 8'hd6
        |=> vectorAddr == 16'hffd6) else $error("serial vector wrong");
    imask_hold_a: assert property (clkEn && ctrlQ[0] && !clockFailReq
        |=> !vectorValid) else $error("masked request taken");
endmodule : ivpm_checker
bind ivpm_top ivpm_checker chk_u (.*);
`default_nettype wire

// [testbench/ivpm_src_model.sv]
`timescale 1ns/1ns
`default_nettype none
// Peripheral sources and the external pin, held as the bench commands
module ivpm_src_model
    import ivpm_pkg::*;
(
    // Bench command: 0 pin, 1 edge, 2 spi, 3-10 serial, 11-15 rest
    input wire logic [15:0] cmd,
    // Request lines
    output logic clockFailReq,
    output logic underflowReq,
    output logic accAEdgeReq,
    output logic spiDoneReq,
    output logic accBOverflowReq,
    output logic lockReq,
    output logic limpHomeReq,
    output ivpm_ser_t ch0Req,
    output ivpm_ser_t ch1Req,
    // Pin, driven high when released
    output logic extIrq_b
);
    // Levels stay until the bench drops them
    assign {clockFailReq, limpHomeReq, lockReq, accBOverflowReq, underflowReq, ch1Req, ch0Req,
        spiDoneReq, accAEdgeReq} = cmd[15:1];
    // Released pin is driven high, never shows a stale low
    assign extIrq_b = ~cmd[0];
endmodule : ivpm_src_model
`default_nettype wire

// [testbench/interrupt_vector_priority_map_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module interrupt_vector_priority_map_tb;
    logic core_clk, rst_b, clkEn, psel, penable, pwrite, pready, pslverr, vectorValid, irq;
    logic clockFailReq, underflowReq, accAEdgeReq, spiDoneReq, accBOverflowReq;
    logic lockReq, limpHomeReq, extIrq_b, rerr;
    logic [3:0] ch0Req, ch1Req;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] vectorAddr, cmd;
    int fail_count, n_tests;
    localparam logic [31:0] ALL = 32'h000f_f07e; // Every maskable enable, monitors off, I clear
    localparam logic [7:0] CODE[7] = '{8'hda, 8'hd8, 8'hd6, 8'hd4, 8'hcc, 8'hca, 8'hc2};
    int bitA[7] = '{1, 2, 5, 9, 11, 12, 13};
    int bitB[7] = '{1, 2, 6, 10, 11, 12, 14};
    ivpm_top dut_u (.*);
    ivpm_src_model src_u (.*);
    always #10 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask : chk
    // One APB transfer; answer taken at the edge where pready is high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge core_clk);
        end
        if (pready !== 1'b1) begin
            fail_count++;
        end
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb
    task settle(input int n);
        repeat (n) @(posedge core_clk);
    endtask : settle
    // Elevation code goes in only while masked
    task elevate(input logic [7:0] c);
        apb(1'b1, 12'h000, ALL | 32'h1);
        apb(1'b1, 12'h004, {24'h0, c});
        apb(1'b1, 12'h000, ALL);
    endtask : elevate
    ////////////////////////////////////////////////////////////
    task t_reset;
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'hf2);
        cmd <= 16'h7ffe;
        settle(3);
        chk(vectorValid, 1'b0);
        cmd <= 16'h0;
    endtask : t_reset
    task t_elev_lock;
        apb(1'b1, 12'h000, ALL);
        apb(1'b1, 12'h004, 32'hcc);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'hf2);
        elevate(8'hcc);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'hcc);
    endtask : t_elev_lock
    // All but the pin pending; each elevated source must win in turn
    task t_elevate;
        logic [15:0] m;
        m = 16'h0;
        foreach (bitA[i]) m[bitA[i]] = 1'b1;
        cmd <= m;
        foreach (CODE[i]) begin
            elevate(CODE[i]);
            settle(3);
            chk(vectorAddr, {8'hff, CODE[i]});
        end
    endtask : t_elevate
    // Default order: drop the winner, the next address follows
    task t_order;
        logic [15:0] m;
        m = 16'h0;
        foreach (bitB[i]) m[bitB[i]] = 1'b1;
        elevate(8'hf2);
        cmd <= m;
        foreach (CODE[i]) begin
            settle(3);
            chk(vectorAddr, {8'hff, CODE[i]});
            m[bitB[i]] = 1'b0;
            cmd <= m;
        end
        settle(3);
        chk(vectorValid, 1'b0);
    endtask : t_order
    task t_gate;
        apb(1'b1, 12'h000, ALL & ~32'h2);
        cmd <= 16'h0800;
        settle(3);
        chk(vectorValid, 1'b0);
        cmd <= 16'h0;
    endtask : t_gate
    // Clock fail ignores I, obeys only the monitor enables
    task t_clkfail;
        cmd <= 16'h8002;
        apb(1'b1, 12'h000, 32'h81);
        settle(3);
        chk(vectorAddr, 16'hfffc);
        apb(1'b1, 12'h000, 32'h101);
        settle(3);
        chk(vectorAddr, 16'hfffc);
        apb(1'b1, 12'h000, ALL | 32'h1);
        settle(3);
        chk(vectorValid, 1'b0);
        cmd <= 16'h0;
    endtask : t_clkfail
    task t_pin;
        logic [7:0] bad[3];
        bad = '{8'hf4, 8'hdb, 8'hdc};
        cmd <= 16'h0003;
        foreach (bad[i]) begin
            elevate(bad[i]);
            settle(8);
            chk(vectorAddr, 16'hfff2);
        end
        cmd <= 16'h0002;
        settle(8);
        chk(vectorAddr, 16'hffda);
        cmd <= 16'h0;
    endtask : t_pin
    // Sticky status, mask, level irq, read clear, unmapped place
    task t_irq;
        apb(1'b1, 12'h00c, 32'h0);
        apb(1'b0, 12'h008, 32'h0);
        cmd <= 16'h0004;
        settle(3);
        cmd <= 16'h0;
        settle(3);
        chk(irq, 1'b0);
        apb(1'b1, 12'h00c, 32'h4);
        chk(irq, 1'b1);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h4);
        chk(irq, 1'b0);
        apb(1'b0, 12'h020, 32'h0);
        chk(rerr, 1'b1);
    endtask : t_irq
    // Enable low freezes everything; the request shows once it rises
    task t_freeze;
        clkEn <= 1'b0;
        cmd <= 16'h0002;
        settle(3);
        chk(vectorValid, 1'b0);
        clkEn <= 1'b1;
        settle(3);
        chk(vectorAddr, 16'hffda);
        cmd <= 16'h0;
    endtask : t_freeze
    ////////////////////////////////////////////////////////////
    task end_sim;
        if (fail_count == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim
    initial begin
        {core_clk, rst_b, psel, penable, pwrite, paddr, pwdata, cmd} = '0;
        clkEn = 1'b1;
        fail_count = 0;
        n_tests = 0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        t_reset();
        t_elev_lock();
        t_elevate();
        t_order();
        t_gate();
        t_clkfail();
        t_pin();
        t_irq();
        t_freeze();
        end_sim();
    end
    // Watchdog, far beyond the expected run
    initial begin
        #400000;
        fail_count++;
        end_sim();
    end
endmodule : interrupt_vector_priority_map_tb
`default_nettype wire
